// file: cond_if.sv
// live condition levels and their change pulses, passed from synchroniser to status logic
`timescale 1ns/1ps
`default_nettype none

interface cond_if;
	import lock_alarm_pkg::*;
	cond_vec_t state;
	cond_vec_t change;
	modport src (output state, output change);
	modport dst (input state, input change);
endinterface

`default_nettype wire

// file: cond_sync.sv
// two-stage synchroniser and change detector for the raw condition levels
`timescale 1ns/1ps
`default_nettype none

module cond_sync
(
	input  wire logic                      clk_sys,
	input  wire logic                      rst_b,
	input  wire lock_alarm_pkg::cond_vec_t raw,
	cond_if.src                            link
);
	import lock_alarm_pkg::*;

	sync_state_t q;
	sync_state_t d;

	// meta is read only by sync; the edge detector looks at sync and prev alone
	always_comb
	begin
		d      = q;
		d.meta = raw;
		d.sync = q.meta;
		d.prev = q.sync;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			q <= '0;
		else
			q <= d;
	end

	assign link.state  = q.sync;
	assign link.change = q.sync ^ q.prev;

endmodule

`default_nettype wire

// file: host_model.sv
// host side of the register port: one-cycle read and write strobes
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	input  wire logic                      clk_sys,
	input  wire lock_alarm_pkg::reg_data_t reg_rdata,
	output var  lock_alarm_pkg::reg_addr_t reg_addr,
	output var  logic                      reg_wr,
	output var  logic                      reg_rd,
	output var  lock_alarm_pkg::reg_data_t reg_wdata
);
	import lock_alarm_pkg::*;
	initial
	begin
		reg_addr = 6'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// called at a rising edge; returns at a rising edge
	task automatic wr(input reg_addr_t a, input reg_data_t d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		// one idle edge, so a second write never lowers and raises the strobe in one step
		@(posedge clk_sys);
	endtask
	// data taken one edge after the strobe edge, before that edge's updates land
	task automatic rd(input reg_addr_t a, output reg_data_t d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// file: lock_alarm_defines.svh
// offsets, bit positions, reset values and sizes of the lock and alarm status logic
`ifndef LOCK_ALARM_DEFINES_SVH
`define LOCK_ALARM_DEFINES_SVH

`define LA_ADDR_W          6
`define LA_ADDR_ENABLE     6'h00
`define LA_ADDR_FLAGS      6'h01
`define LA_ADDR_STATUS     6'h02
`define LA_NUM_COND        5
`define LA_BIT_OSC         4
`define LA_BIT_LOSS        3
`define LA_BIT_RECOVERY    2
`define LA_BIT_MULTIPLIER  1
`define LA_BIT_OVERFLOW    0
`define LA_RST_ENABLE      5'h00
`define LA_RST_FLAGS       5'h00
`define LA_RST_DATA        8'h00
`define LA_SYNC_STAGES     2

`endif

// file: lock_alarm_interrupt_status.sv
// change flags, live status, enable mask and interrupt of the lock and alarm conditions
//
// Overview of operation
// (RL1) oscillator lock change sets flag bit 4; zero means no change.
// (RL2) loss-of-signal change sets flag bit 3; zero means no change.
// (RL3) recovery lock change sets flag bit 2; zero means no change.
// (RL4) multiplier lock change sets flag bit 1; zero means no change.
// (RL5) overflow change sets flag bit 0; zero means no change.
// (RL6) no interrupt for a flag unless its enable bit at address zero is one.
// (RL7) oscillator lock flag and status only meaningful while its detection is enabled.
// (RL8) status bit 4 high while reference locked to external oscillator.
// (RL9) status bit 3 high while loss-of-signal alarm present.
// (RL10) status bit 2 high while clock and data recovery locked.
// (RL11) status bit 1 high while transmit multiplier locked.
// (RL12) status bit 0 high while transmit overflow exists.
// (RL13) bits 7 to 5 of both status registers unused; software ignores them.
// (RL14) enable bit zero masks its condition, one permits it.
// (RL15) flag register read returns flags then clears them; changes meanwhile stay.
// (RL16) interrupt high while any flag and its enable set; reset clears all.
`timescale 1ns/1ps
`default_nettype none
`include "lock_alarm_defines.svh"

module lock_alarm_interrupt_status
#(
	parameter int NUM_COND = `LA_NUM_COND
)
(
	input  wire logic                      clk_sys,
	input  wire logic                      rst_b,
	input  wire lock_alarm_pkg::cond_vec_t raw_cond,
	input  wire logic                      osc_lock_detect_enable,
	input  wire lock_alarm_pkg::reg_addr_t reg_addr,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	input  wire lock_alarm_pkg::reg_data_t reg_wdata,
	output var  lock_alarm_pkg::reg_data_t reg_rdata,
	output var  logic                      irq
);
	import lock_alarm_pkg::*;

	if (NUM_COND != `LA_NUM_COND)
	begin : g_bad_width
		$error("condition count must match the status register layout");
	end

	cond_if link ();

	cond_sync u_sync
	(
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.raw     (raw_cond),
		.link    (link.src)
	);

	function automatic logic hit(input reg_addr_t a, input reg_addr_t target);
		hit = (a == target);
	endfunction

	status_state_t q;
	status_state_t d;
	cond_vec_t     live;
	cond_vec_t     chg;
	cond_vec_t     clr;
	logic          rd_flags;
	logic          rd_status;
	logic          wr_enable;

	always_comb
	begin
		d         = q;
		rd_flags  = reg_rd && hit(reg_addr, `LA_ADDR_FLAGS);
		rd_status = reg_rd && hit(reg_addr, `LA_ADDR_STATUS);
		wr_enable = reg_wr && hit(reg_addr, `LA_ADDR_ENABLE);
		// live levels map bit for bit onto the status register
		live = link.state; // RL8 RL9 RL10 RL11 RL12
		chg  = link.change; // RL1 RL2 RL3 RL4 RL5
		// oscillator lock reads and flags nothing while its detector is off
		live[`LA_BIT_OSC] = link.state[`LA_BIT_OSC] & osc_lock_detect_enable; // RL7
		chg[`LA_BIT_OSC]  = link.change[`LA_BIT_OSC] & osc_lock_detect_enable; // RL7
		if (wr_enable)
			d.en = reg_wdata[NUM_COND-1:0]; // RL14
		clr = rd_flags ? q.flag : '0; // RL15
		// a change in the reading cycle survives the clear
		d.flag = (q.flag & ~clr) | chg; // RL1 RL2 RL3 RL4 RL5 RL15
		if (reg_rd)
		begin
			if (hit(reg_addr, `LA_ADDR_ENABLE))
				d.rd_data = {3'h0, q.en};
			else if (rd_flags)
				d.rd_data = {3'h0, q.flag}; // RL13 RL15
			else if (rd_status)
				d.rd_data = {3'h0, live}; // RL13
			else
				d.rd_data = `LA_RST_DATA;
		end
		d.irq = |(d.flag & d.en); // RL6 RL14 RL16
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q.en      <= `LA_RST_ENABLE;
			q.flag    <= `LA_RST_FLAGS; // RL16
			q.rd_data <= `LA_RST_DATA;
			q.irq     <= 1'b0; // RL16
		end
		else
			q <= d;
	end

	assign reg_rdata = q.rd_data;
	assign irq       = q.irq;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	flag_set_a: assert property ( // RL1 RL2 RL3 RL4 RL5
		(|chg) |=> ((q.flag & $past(chg)) == $past(chg)))
		else $error("a seen change was not latched");

	flag_hold_a: assert property ( // RL15
		!rd_flags |=> ((q.flag & $past(q.flag)) == $past(q.flag)))
		else $error("flag dropped without a read");

	read_clear_a: assert property ( // RL15
		(rd_flags && chg == '0) |=> (q.flag == '0))
		else $error("flag read did not clear flags");

	read_return_a: assert property ( // RL15
		rd_flags |=> (reg_rdata == {3'h0, $past(q.flag)}))
		else $error("flag read returned wrong value");

	status_live_a: assert property ( // RL9 RL10 RL11 RL12
		rd_status |=> (reg_rdata[3:0] == $past(link.state[3:0])))
		else $error("status read does not show live levels");

	osc_gate_a: assert property ( // RL7
		(rd_status && !osc_lock_detect_enable) |=> !reg_rdata[`LA_BIT_OSC])
		else $error("oscillator lock shown while detection off");

	reserved_zero_a: assert property ( // RL13
		reg_rdata[7:5] == 3'h0)
		else $error("unused bits not zero");

	irq_masked_a: assert property ( // RL6 RL14
		irq |-> (|(q.flag & q.en)))
		else $error("interrupt without enabled flag");

	irq_raised_a: assert property ( // RL16
		(|(q.flag & q.en)) |-> irq)
		else $error("enabled flag did not raise interrupt");

	enable_write_a: assert property ( // RL14
		wr_enable |=> (q.en == $past(reg_wdata[4:0])))
		else $error("enable write not stored");

	// a level change is the only way into a flag
	flag_only_change_a: assert property ( // RL1 RL2 RL3 RL4 RL5
		(chg == '0) |=> ((q.flag & ~$past(q.flag)) == '0))
		else $error("flag set without a change");

	osc_flag_gate_a: assert property ( // RL7
		(!osc_lock_detect_enable && !q.flag[`LA_BIT_OSC]) |=> !q.flag[`LA_BIT_OSC])
		else $error("oscillator lock flag set while detection off");

	osc_status_a: assert property ( // RL8
		(rd_status && osc_lock_detect_enable) |=>
			(reg_rdata[`LA_BIT_OSC] == $past(link.state[`LA_BIT_OSC])))
		else $error("oscillator lock status does not follow its level");

	rdata_hold_a: assert property ( // RL15
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	enable_read_a: assert property ( // RL14
		(reg_rd && reg_addr == `LA_ADDR_ENABLE) |=> (reg_rdata == {3'h0, $past(q.en)}))
		else $error("enable read returned wrong value");

	unmapped_read_a: assert property ( // RL13
		(reg_rd && reg_addr > `LA_ADDR_STATUS) |=> (reg_rdata == `LA_RST_DATA))
		else $error("unmapped read not zero");

	enable_hold_a: assert property ( // RL14
		!wr_enable |=> $stable(q.en))
		else $error("enable changed without a write");

	irq_off_a: assert property ( // RL6 RL14
		(q.en == '0) |-> !irq)
		else $error("interrupt with every enable clear");

	irq_change_a: assert property ( // RL16
		((chg & q.en) != '0 && !wr_enable) |=> irq)
		else $error("enabled change did not raise interrupt");

	read_irq_clear_a: assert property ( // RL15 RL16
		(rd_flags && chg == '0) |=> !irq)
		else $error("flag read left interrupt high");

	irq_drop_a: assert property ( // RL6 RL14
		(wr_enable && reg_wdata[4:0] == '0) |=> !irq)
		else $error("interrupt stayed high after enables cleared");

	// watched through reset, so this one alone overrides the default disable
	reset_clear_a: assert property ( // RL16
		disable iff (1'b0)
		!rst_b |-> (!irq && reg_rdata == `LA_RST_DATA &&
			q.flag == `LA_RST_FLAGS && q.en == `LA_RST_ENABLE))
		else $error("reset left state behind");

	// one pair per condition bit
	for (genvar i = 0; i < NUM_COND; i++)
	begin : g_bit
		bit_clear_a: assert property ( // RL15
			@(posedge clk_sys) disable iff (!rst_b) (rd_flags && !chg[i]) |=> !q.flag[i])
			else $error("flag bit survived its read");

		bit_irq_a: assert property ( // RL6 RL16
			@(posedge clk_sys) disable iff (!rst_b) (q.flag[i] && q.en[i]) |-> irq)
			else $error("enabled flag bit without interrupt");
	end

endmodule

`default_nettype wire

// file: lock_alarm_pkg.sv
// types shared by the lock and alarm status logic
`default_nettype none
`include "lock_alarm_defines.svh"

package lock_alarm_pkg;

	typedef logic [`LA_NUM_COND-1:0] cond_vec_t;
	typedef logic [`LA_ADDR_W-1:0]   reg_addr_t;
	typedef logic [7:0]              reg_data_t;

	typedef struct packed {
		cond_vec_t meta;
		cond_vec_t sync;
		cond_vec_t prev;
	} sync_state_t;

	typedef struct packed {
		cond_vec_t en;
		cond_vec_t flag;
		reg_data_t rd_data;
		logic      irq;
	} status_state_t;

endpackage

`default_nettype wire

// file: test_lock_alarm_interrupt_status.sv
// self-checking bench of the lock and alarm status logic
`timescale 1ns/1ps
`default_nettype none
`include "lock_alarm_defines.svh"
module test_lock_alarm_interrupt_status;
	import lock_alarm_pkg::*;
	logic      clk_sys;
	logic      rst_b;
	cond_vec_t raw_cond;
	logic      det_en;
	reg_addr_t reg_addr;
	logic      reg_wr;
	logic      reg_rd;
	reg_data_t reg_wdata;
	reg_data_t reg_rdata;
	logic      irq;
	reg_data_t got;
	int        err_count;
	int        tests_run;
	lock_alarm_interrupt_status DUT (.clk_sys(clk_sys), .rst_b(rst_b), .raw_cond(raw_cond),
		.osc_lock_detect_enable(det_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq(irq));
	host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
	task automatic chk(input reg_data_t g, input reg_data_t e);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic close_out;
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// far longer than the roughly 124 cycles the sequence needs
	initial
	begin
		#50000;
		err_count++;
		close_out();
	end
	initial
	begin
		err_count = 0;
		tests_run = 0;
		rst_b = 1'b0;
		raw_cond = 5'h00;
		det_en = 1'b1;
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		chk({7'h00, irq}, 8'h00);
		host.rd(`LA_ADDR_FLAGS, got);
		chk(got, 8'h00);
		host.wr(`LA_ADDR_ENABLE, 8'h1f);
		host.rd(`LA_ADDR_ENABLE, got);
		chk(got, 8'h1f);
		host.wr(`LA_ADDR_STATUS, 8'hff);
		host.rd(`LA_ADDR_STATUS, got);
		chk(got, 8'h00);
		host.rd(6'h3f, got);
		chk(got, 8'h00);
		// raise one condition at a time, lowest bit first
		for (int i = 0; i < 5; i++)
		begin
			raw_cond <= raw_cond | cond_vec_t'(1 << i);
			repeat (5) @(posedge clk_sys);
			chk({7'h00, irq}, 8'h01);
			host.rd(`LA_ADDR_STATUS, got);
			chk(got, {3'h0, raw_cond});
			host.rd(`LA_ADDR_FLAGS, got);
			chk(got, 8'h01 << i);
			host.rd(`LA_ADDR_FLAGS, got);
			chk(got, 8'h00);
			chk({7'h00, irq}, 8'h00);
		end
		// change lands in the cycle of the read: it must survive the clear
		raw_cond <= 5'h1e;
		repeat (2) @(posedge clk_sys);
		host.rd(`LA_ADDR_FLAGS, got);
		chk(got, 8'h00);
		host.rd(`LA_ADDR_FLAGS, got);
		chk(got, 8'h01);
		host.wr(`LA_ADDR_ENABLE, 8'h17);
		raw_cond <= 5'h16;
		repeat (5) @(posedge clk_sys);
		chk({7'h00, irq}, 8'h00);
		host.rd(`LA_ADDR_FLAGS, got);
		chk(got, 8'h08);
		det_en <= 1'b0;
		raw_cond <= 5'h06;
		repeat (5) @(posedge clk_sys);
		host.rd(`LA_ADDR_STATUS, got);
		chk(got, 8'h06);
		host.rd(`LA_ADDR_FLAGS, got);
		chk(got, 8'h00);
		raw_cond <= 5'h07;
		repeat (5) @(posedge clk_sys);
		chk({7'h00, irq}, 8'h01);
		host.rd(`LA_ADDR_ENABLE, got);
		chk(got, 8'h17);
		// mid-run reset: flags, enables, read data and interrupt return to zero
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk({7'h00, irq}, 8'h00);
		chk(reg_rdata, 8'h00);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		host.rd(`LA_ADDR_FLAGS, got);
		chk(got, 8'h00);
		host.rd(`LA_ADDR_ENABLE, got);
		chk(got, 8'h00);
		// levels already high at release show up as one change each
		host.wr(`LA_ADDR_ENABLE, 8'h1f);
		chk({7'h00, irq}, 8'h01);
		host.wr(`LA_ADDR_ENABLE, 8'h00);
		chk({7'h00, irq}, 8'h00);
		host.rd(`LA_ADDR_FLAGS, got);
		chk(got, 8'h07);
		close_out();
	end
endmodule
`default_nettype wire
